// ### cls_logic_cells.sv
// Eleven configurable table/storage/shift cells with host byte access
`timescale 1ns/100ps
module cls_logic_cells
   import cls_pkg::*;
#(
   parameter int CHAIN_BITS = cls_pkg::CLS_CHAIN_BITS
) (
   input wire logic clk,
   input wire logic arst_n,
   // Routed inputs from the routing matrix
   input wire logic [3:0] pairIn,
   input wire logic [23:0] tripleIn,
   input wire logic [3:0] quadIn,
   // Outputs back to the routing matrix
   output logic [1:0] pairOut,
   output logic [7:0] tripleOut,
   output logic quadOut,
   // Non-volatile configuration, static after power-up
   input wire logic [7:0] nvmPairTruth,
   input wire logic [1:0] nvmPairStore,
   input wire logic [1:0] nvmPairLatch,
   input wire logic [63:0] nvmTripleTruth,
   input wire logic [15:0] nvmTripleFunc,
   input wire logic [7:0] nvmTripleLatch,
   input wire logic [7:0] nvmTriplePolarity,
   input wire logic [7:0] nvmTriplePreset,
   input wire logic [3:0] nvmShiftInvert,
   input wire logic [11:0] nvmShiftLength,
   input wire logic [31:0] nvmShiftInit,
   input wire logic [10:0] nvmStoreInit,
   input wire logic [15:0] nvmQuadTruth,
   input wire logic nvmQuadStore,
   input wire logic nvmQuadLatch,
   input wire logic nvmQuadPolarity,
   input wire logic nvmQuadPreset,
   // Byte access from the serial interface controller
   input wire logic hostWrite,
   input wire logic hostRead,
   input wire logic [7:0] hostAddr,
   input wire logic [7:0] hostWdata,
   output logic [7:0] hostRdata,
   output logic hostRdValid
);
   import cls_pkg::*;

   if (CHAIN_BITS != CLS_CHAIN_BITS) begin : gBadChain
      $error("cls_logic_cells: CHAIN_BITS must equal 8 for a 3-bit length select");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   function automatic logic tablePick(input logic [15:0] truth, input logic [3:0] idx);
      return truth[idx];
   endfunction

   function automatic logic storeStep(input logic latchSel, input logic clkNow,
                                      input logic clkPrev, input logic d, input logic q);
      logic r;
      r = q;
      if (latchSel) begin
         if (!clkNow) begin
            r = d;
         end
      end else if (clkNow && !clkPrev) begin
         r = d;
      end
      return r;
   endfunction

   function automatic logic clearOn(input logic polHigh, input logic level);
      return polHigh ? level : !level;
   endfunction

   function automatic cls_func_t funcDecode(input logic [1:0] code, input logic shiftOk);
      cls_func_t f;
      unique case (code)
         CLS_CODE_TABLE: f = CLS_FN_TABLE;
         CLS_CODE_STORE: f = CLS_FN_STORE;
         CLS_CODE_SHIFT: f = shiftOk ? CLS_FN_SHIFT : CLS_FN_STORE;
         default: f = CLS_FN_TABLE;
      endcase
      return f;
   endfunction

   // Returns {hit, chain index}
   function automatic logic [2:0] chainSlot(input logic [7:0] addr);
      logic [2:0] s;
      s = 3'h0;
      unique case (addr)
         CLS_CHAIN0_ADDR: s = 3'h4;
         CLS_CHAIN1_ADDR: s = 3'h5;
         CLS_CHAIN2_ADDR: s = 3'h6;
         CLS_CHAIN3_ADDR: s = 3'h7;
         default: s = 3'h0;
      endcase
      return s;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   logic [CLS_SYNC_W-1:0] syncA;
   logic [CLS_SYNC_W-1:0] syncB;
   logic [CLS_SYNC_W-1:0] syncPrev;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         syncA <= '0;
         syncB <= '0;
         syncPrev <= '0;
      end else begin
         syncA <= {quadIn, tripleIn, pairIn};
         syncB <= syncA;
         syncPrev <= syncB;
      end
   end

   logic [3:0] pairS;
   logic [3:0] pairP;
   logic [23:0] tripleS;
   logic [23:0] tripleP;
   logic [3:0] quadS;
   logic [3:0] quadP;

   assign pairS = syncB[3:0];
   assign pairP = syncPrev[3:0];
   assign tripleS = syncB[27:4];
   assign tripleP = syncPrev[27:4];
   assign quadS = syncB[31:28];
   assign quadP = syncPrev[31:28];

   ////////////////////////////////////////////////////////////////////////////
   // Configuration capture after reset release

   logic loaded;
   logic [7:0] pairTruth;
   logic [1:0] pairStore;
   logic [1:0] pairLatch;
   logic [63:0] tripleTruth;
   cls_func_t tripleFunc [CLS_TRIPLE_CELLS];
   logic [7:0] tripleLatch;
   logic [7:0] triplePol;
   logic [7:0] triplePreset;
   logic [3:0] shiftInvert;
   logic [11:0] shiftLength;
   logic [15:0] quadTruth;
   logic quadStore;
   logic quadLatch;
   logic quadPol;
   logic quadPreset;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         loaded <= CLS_LOADED_RST;
         pairTruth <= '0;
         pairStore <= '0;
         pairLatch <= '0;
         tripleTruth <= '0;
         for (int c = 0; c < CLS_TRIPLE_CELLS; c++) begin
            tripleFunc[c] <= CLS_FN_TABLE;
         end
         tripleLatch <= '0;
         triplePol <= '0;
         triplePreset <= '0;
         shiftInvert <= '0;
         shiftLength <= '0;
         quadTruth <= '0;
         quadStore <= 1'b0;
         quadLatch <= 1'b0;
         quadPol <= 1'b0;
         quadPreset <= 1'b0;
      end else if (!loaded) begin
         loaded <= 1'b1;
         pairTruth <= nvmPairTruth;
         pairStore <= nvmPairStore;
         pairLatch <= nvmPairLatch;
         tripleTruth <= nvmTripleTruth;
         for (int c = 0; c < CLS_TRIPLE_CELLS; c++) begin
            tripleFunc[c] <= funcDecode(nvmTripleFunc[c*2 +: 2], c >= CLS_SHIFT_BASE);
         end
         tripleLatch <= nvmTripleLatch;
         triplePol <= nvmTriplePolarity;
         triplePreset <= nvmTriplePreset;
         shiftInvert <= nvmShiftInvert;
         shiftLength <= nvmShiftLength;
         quadTruth <= nvmQuadTruth;
         quadStore <= nvmQuadStore;
         quadLatch <= nvmQuadLatch;
         quadPol <= nvmQuadPolarity;
         quadPreset <= nvmQuadPreset;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Plain storage cells: pairs, triples 0..3, quad

   logic [1:0] pairQ;
   logic [3:0] tripleQ;
   logic quadQ;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pairQ <= '0;
         tripleQ <= '0;
         quadQ <= 1'b0;
      end else if (!loaded) begin
         pairQ <= nvmStoreInit[1:0];
         tripleQ <= nvmStoreInit[5:2];
         quadQ <= nvmStoreInit[10];
      end else begin
         for (int c = 0; c < CLS_PAIR_CELLS; c++) begin
            // IN0 is clock, IN1 is data, no clear input
            pairQ[c] <= storeStep(pairLatch[c], pairS[c*2], pairP[c*2],
                                  pairS[c*2+1], pairQ[c]);
         end
         for (int c = 0; c < CLS_SHIFT_BASE; c++) begin
            if (clearOn(triplePol[c], tripleS[c*3+2])) begin
               tripleQ[c] <= triplePreset[c];
            end else begin
               tripleQ[c] <= storeStep(tripleLatch[c], tripleS[c*3], tripleP[c*3],
                                       tripleS[c*3+1], tripleQ[c]);
            end
         end
         if (clearOn(quadPol, quadS[2])) begin
            quadQ <= quadPreset;
         end else begin
            quadQ <= storeStep(quadLatch, quadS[0], quadP[0], quadS[1], quadQ);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shift chains, also used as storage in the shift-capable cells

   logic [CHAIN_BITS-1:0] chain [CLS_SHIFT_CELLS];
   logic [2:0] wrSlot;
   logic [2:0] rdSlot;

   assign wrSlot = chainSlot(hostAddr);
   assign rdSlot = wrSlot;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int s = 0; s < CLS_SHIFT_CELLS; s++) begin
            chain[s] <= CLS_CHAIN_RST;
         end
      end else if (!loaded) begin
         for (int s = 0; s < CLS_SHIFT_CELLS; s++) begin
            chain[s] <= nvmShiftInit[s*8 +: 8];
         end
      end else begin
         for (int s = 0; s < CLS_SHIFT_CELLS; s++) begin
            int c;
            logic ck;
            logic cp;
            logic d;
            logic oneBit;
            c = s + CLS_SHIFT_BASE;
            ck = tripleS[c*3];
            cp = tripleP[c*3];
            d = tripleS[c*3+1];
            oneBit = (tripleFunc[c] == CLS_FN_STORE) || (shiftLength[s*3 +: 3] == 3'h0);
            if (tripleFunc[c] != CLS_FN_TABLE && clearOn(triplePol[c], tripleS[c*3+2])) begin
               chain[s] <= {CHAIN_BITS{triplePreset[c]}};
            end else if (hostWrite && wrSlot[2] && wrSlot[1:0] == s[1:0]) begin
               chain[s] <= hostWdata;
            end else if (tripleFunc[c] != CLS_FN_TABLE && oneBit) begin
               // Store function or length one: single storage bit at the MSB
               chain[s][CHAIN_BITS-1] <= storeStep(tripleLatch[c], ck, cp, d,
                                                   chain[s][CHAIN_BITS-1]);
            end else if (tripleFunc[c] == CLS_FN_SHIFT && ck && !cp) begin
               chain[s] <= {d, chain[s][CHAIN_BITS-1:1]};
            end
         end
      end
   end

   // Read snapshot taken on the internal clock, unrelated to the chain clock
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hostRdata <= CLS_RDATA_RST;
         hostRdValid <= 1'b0;
      end else begin
         hostRdValid <= hostRead;
         if (hostRead) begin
            hostRdata <= rdSlot[2] ? chain[rdSlot[1:0]] : CLS_RDATA_RST;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output selection, registered

   logic [1:0] next_pairOut;
   logic [7:0] next_tripleOut;
   logic next_quadOut;

   always_comb begin
      for (int c = 0; c < CLS_PAIR_CELLS; c++) begin
         next_pairOut[c] = pairStore[c] ? pairQ[c]
            : tablePick({12'h000, pairTruth[c*4 +: 4]},
                        {2'b00, pairS[c*2+1], pairS[c*2]});
      end
      for (int c = 0; c < CLS_TRIPLE_CELLS; c++) begin
         logic tab;
         logic st;
         tab = tablePick({8'h00, tripleTruth[c*8 +: 8]},
                         {1'b0, tripleS[c*3+2], tripleS[c*3+1], tripleS[c*3]});
         st = 1'b0;
         if (c < CLS_SHIFT_BASE) begin
            st = tripleQ[c[1:0]];
         end else if (tripleFunc[c] == CLS_FN_SHIFT) begin
            // Chain end is the bit length-1 places below the MSB
            st = chain[c-CLS_SHIFT_BASE][3'(CHAIN_BITS - 1) - shiftLength[(c-4)*3 +: 3]];
         end else begin
            st = chain[c-CLS_SHIFT_BASE][CHAIN_BITS-1];
         end
         next_tripleOut[c] = (tripleFunc[c] == CLS_FN_TABLE) ? tab : st;
         if (c >= CLS_SHIFT_BASE) begin
            next_tripleOut[c] = next_tripleOut[c] ^ shiftInvert[c-CLS_SHIFT_BASE];
         end
      end
      next_quadOut = quadStore ? quadQ : tablePick(quadTruth, quadS);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pairOut <= {CLS_PAIR_CELLS{CLS_OUT_RST}};
         tripleOut <= {CLS_TRIPLE_CELLS{CLS_OUT_RST}};
         quadOut <= CLS_OUT_RST;
      end else if (loaded) begin
         pairOut <= next_pairOut;
         tripleOut <= next_tripleOut;
         quadOut <= next_quadOut;
      end
   end
endmodule

// ### cls_logic_cells_bench.sv
// Self-checking bench for the logic cell block
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
   $display("Error t=%0t got %h exp %h", $time, a, e); end end
module cls_logic_cells_bench;
   import cls_pkg::*;
   logic clk = 1'b0, arst_n = 1'b0, hold = 1'b0, hostWrite = 1'b0, hostRead = 1'b0;
   logic [7:0] hostAddr = 8'h00, hostWdata = 8'h00, hostRdata, er, w;
   logic [3:0] nxtPair = 4'h0, nxtQuad = 4'h0, pairIn, quadIn;
   logic [23:0] nxtTriple = 24'h0, tripleIn;
   logic [1:0] pairOut, nvmPairStore, nvmPairLatch;
   logic [7:0] tripleOut, nvmPairTruth, nvmTripleLatch, nvmTriplePolarity, nvmTriplePreset;
   logic quadOut, hostRdValid, nvmQuadStore, nvmQuadLatch, nvmQuadPolarity, nvmQuadPreset;
   logic [63:0] nvmTripleTruth;
   logic [15:0] nvmTripleFunc, nvmQuadTruth;
   logic [3:0] nvmShiftInvert;
   logic [11:0] nvmShiftLength;
   logic [31:0] nvmShiftInit;
   logic [10:0] nvmStoreInit, st, eo;
   logic [3:0][7:0] chain;
   logic [10:0] expOut[$];
   logic [7:0] expRd[$];
   int seed, errors = 0, checks_done = 0;
   event probe;
   always #20 clk = ~clk;
   cls_route_model i_route (.clk, .hold, .nxtPair, .nxtTriple, .nxtQuad, .pairIn,
      .tripleIn, .quadIn);
   cls_logic_cells i_dut (.clk, .arst_n, .pairIn, .tripleIn, .quadIn, .pairOut, .tripleOut,
      .quadOut, .nvmPairTruth, .nvmPairStore, .nvmPairLatch, .nvmTripleTruth, .nvmTripleFunc,
      .nvmTripleLatch, .nvmTriplePolarity, .nvmTriplePreset, .nvmShiftInvert, .nvmShiftLength,
      .nvmShiftInit, .nvmStoreInit, .nvmQuadTruth, .nvmQuadStore, .nvmQuadLatch,
      .nvmQuadPolarity, .nvmQuadPreset, .hostWrite, .hostRead, .hostAddr, .hostWdata,
      .hostRdata, .hostRdValid);
   ////////////////////////////////////////////////////////////////
   function automatic logic nxt(logic q, ck, cp, d, ca, pre, lat);
      if (ca) return pre;
      if (lat ? !ck : (ck && !cp)) return d;
      return q;
   endfunction
   task automatic stepModel(input logic [3:0] pp, input logic [23:0] tp, input logic [3:0] qp);
      for (int c = 0; c < 2; c++) st[c] = nxt(st[c], pairIn[2*c], pp[2*c],
         pairIn[2*c+1], 1'b0, 1'b0, nvmPairLatch[c]);
      for (int c = 0; c < 4; c++) st[2+c] = nxt(st[2+c], tripleIn[3*c], tp[3*c],
         tripleIn[3*c+1], tripleIn[3*c+2] == nvmTriplePolarity[c], nvmTriplePreset[c],
         nvmTripleLatch[c]);
      st[10] = nxt(st[10], quadIn[0], qp[0], quadIn[1], quadIn[2] == nvmQuadPolarity,
         nvmQuadPreset, nvmQuadLatch);
      for (int s = 0; s < 4; s++) if (tripleIn[3*s+12] && !tp[3*s+12]) begin
         // Length one keeps a single stored bit at the MSB, the rest stays put
         if (nvmShiftLength[3*s+:3] == 3'h0) chain[s][7] = tripleIn[3*s+13];
         else chain[s] = {tripleIn[3*s+13], chain[s][7:1]};
      end
   endtask
   function automatic logic [10:0] expVec();
      logic [10:0] v;
      if (!nvmPairStore[0]) begin
         v[0] = pairIn[0] & pairIn[1];
         v[1] = pairIn[2] ^ pairIn[3];
         for (int c = 0; c < 8; c++) v[2+c] = nvmTripleTruth[8*c+tripleIn[3*c+:3]];
         v[10] = ^quadIn;
      end else begin
         v = st;
         for (int s = 0; s < 4; s++) v[6+s] = chain[s][7-nvmShiftLength[3*s+:3]];
      end
      v[9:6] = v[9:6] ^ nvmShiftInvert;
      return v;
   endfunction
   task automatic note();
      expOut.push_back(expVec());
      -> probe;
   endtask
   always @(probe) begin
      eo = expOut.pop_front();
      `CHK({quadOut, tripleOut, pairOut}, eo)
   end
   always @(negedge clk) begin
      if (hostRdValid === 1'b1 && expRd.size() > 0) begin
         er = expRd.pop_front();
         `CHK(hostRdata, er)
      end
   end
   task automatic step(input logic [1:0] kind);
      logic [3:0] pp, qp, cp, cq;
      logic [23:0] tp, ct;
      pp = pairIn;
      tp = tripleIn;
      qp = quadIn;
      cp = kind[1] ? 4'hF : kind[0] ? 4'h5 : 4'hA;
      ct = kind[1] ? 24'hFFFFFF : kind[0] ? 24'h249249 : 24'hDB6DB6;
      cq = kind[1] ? 4'hF : kind[0] ? 4'h1 : 4'hE;
      nxtPair = (pp & ~cp) | (4'($random(seed)) & cp);
      nxtTriple = ((tp & ~ct) | (24'($random(seed)) & ct)) & 24'h6DBFFF;
      nxtQuad = (qp & ~cq) | (4'($random(seed)) & cq);
      repeat (8) @(posedge clk);
      #1;
      stepModel(pp, tp, qp);
      note();
   endtask
   task automatic rst(input int n);
      arst_n = 1'b0;
      repeat (n) @(posedge clk);
      #1;
      arst_n = 1'b1;
      st = nvmStoreInit;
      chain = nvmShiftInit;
      stepModel(pairIn, tripleIn, quadIn);
      repeat (6) @(posedge clk);
      #1;
      note();
   endtask
   task automatic wrap_up();
      $display("Checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic hostRd(input logic [7:0] a, input logic [7:0] e);
      int n;
      hold = 1'b1;
      hostRead = 1'b1;
      hostAddr = a;
      expRd.push_back(e);
      @(posedge clk);
      #1;
      hostRead = 1'b0;
      n = 0;
      while (hostRdValid !== 1'b1 && n < 4) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 4) begin
         errors++;
         wrap_up();
      end
      @(posedge clk);
      #1;
      hold = 1'b0;
   endtask
   task automatic hostWr(input logic [7:0] a, input logic [7:0] d);
      hostWrite = 1'b1;
      hostAddr = a;
      hostWdata = d;
      @(posedge clk);
      #1;
      hostWrite = 1'b0;
   endtask
   initial begin
      seed = 73;
      {nvmPairStore, nvmPairLatch, nvmTripleLatch, nvmTriplePolarity, nvmTriplePreset} = '0;
      {nvmQuadStore, nvmQuadLatch, nvmQuadPolarity, nvmQuadPreset, nvmShiftLength} = '0;
      {nvmShiftInit, nvmStoreInit} = '0;
      nvmPairTruth = 8'h68;
      nvmTripleTruth = {$random(seed), $random(seed)};
      nvmTripleFunc = 16'hF0C3;
      nvmShiftInvert = 4'h5;
      nvmQuadTruth = 16'h6996;
      rst(16);
      repeat (12) step(2'h2);
      {nxtPair, nxtTriple, nxtQuad} = '0;
      repeat (2) @(posedge clk);
      #1;
      arst_n = 1'b0;
      {nvmPairStore, nvmPairLatch, nvmTripleLatch, nvmTriplePolarity} = 20'hE0AF6;
      nvmTriplePreset = 8'($random(seed));
      nvmTripleFunc = 16'hAA55;
      nvmShiftLength = {3'h7, 3'h2, 3'h0, 3'h7};
      nvmShiftInit = $random(seed);
      nvmStoreInit = 11'($random(seed));
      nvmShiftInvert = 4'h2;
      {nvmQuadStore, nvmQuadLatch, nvmQuadPolarity, nvmQuadPreset} = 4'h9;
      rst(4);
      for (int i = 0; i < 16; i++) step({1'b0, i[0]});
      for (int s = 0; s < 4; s++) begin
         repeat (2) hostRd(CLS_CHAIN0_ADDR + 8'(2*s), chain[s]);
         w = 8'($random(seed));
         hostWr(CLS_CHAIN0_ADDR + 8'(2*s), w);
         chain[s] = w;
         repeat (3) @(posedge clk);
         #1;
         note();
         hostRd(CLS_CHAIN0_ADDR + 8'(2*s), w);
      end
      hostWr(8'h89, 8'h5A);
      hostRd(8'h8B, 8'h00);
      hostRd(CLS_CHAIN0_ADDR, chain[0]);
      for (int i = 0; i < 8; i++) step({1'b0, i[0]});
      wrap_up();
   end
endmodule

// ### cls_logic_cells_properties.sv
// Port properties of the logic cell block
`timescale 1ns/100ps
module cls_logic_cells_properties
   import cls_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [3:0] pairIn,
   input wire logic [23:0] tripleIn,
   input wire logic [1:0] pairOut,
   input wire logic [7:0] tripleOut,
   input wire logic [7:0] nvmPairTruth,
   input wire logic [1:0] nvmPairStore,
   input wire logic [1:0] nvmPairLatch,
   input wire logic [63:0] nvmTripleTruth,
   input wire logic [15:0] nvmTripleFunc,
   input wire logic [7:0] nvmTriplePolarity,
   input wire logic [7:0] nvmTriplePreset,
   input wire logic hostRead,
   input wire logic [7:0] hostAddr,
   input wire logic [7:0] hostRdata,
   input wire logic hostRdValid
);
   logic [2:0] upCnt;
   logic ready;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         upCnt <= 3'h0;
      end else if (upCnt != 3'h7) begin
         upCnt <= upCnt + 3'h1;
      end
   end
   assign ready = (upCnt >= 3'h3);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   AST_READ_ANSWER: assert property (ready && hostRead |=> hostRdValid)
      else $error("read not answered");
   AST_VALID_CAUSE: assert property (hostRdValid |-> $past(hostRead))
      else $error("valid without read");
   AST_UNMAPPED_ZERO: assert property (ready && hostRead
      && (hostAddr[7:3] != 5'h11 || hostAddr[0]) |=> hostRdata == CLS_RDATA_RST)
      else $error("unmapped read not zero");
   AST_RDATA_HOLD: assert property (ready && !hostRead |=> $stable(hostRdata))
      else $error("read data moved");
   AST_PAIR_TABLE: assert property ((ready && !nvmPairStore[0] && $stable(pairIn))[*4]
      |-> pairOut[0] == nvmPairTruth[pairIn[1:0]]) else $error("pair table wrong");
   AST_TRIPLE_TABLE: assert property ((ready && nvmTripleFunc[0] == nvmTripleFunc[1]
      && $stable(tripleIn))[*4] |-> tripleOut[0] == nvmTripleTruth[tripleIn[2:0]])
      else $error("triple table wrong");
   AST_EDGE_CAPTURE: assert property (ready && nvmPairStore[0] && !nvmPairLatch[0]
      && $rose(pairIn[0]) && $stable(pairIn[1]) ##1 $stable(pairIn)[*5]
      |-> pairOut[0] == pairIn[1]) else $error("edge capture wrong");
   AST_LATCH_FOLLOW: assert property ((ready && nvmPairStore[1] && nvmPairLatch[1]
      && !pairIn[2] && $stable(pairIn[3:2]))[*5] |-> pairOut[1] == pairIn[3])
      else $error("latch not following");
   AST_LATCH_HOLD: assert property ((ready && nvmPairStore[1] && nvmPairLatch[1]
      && pairIn[2] && $stable(pairIn[2]))[*5] |-> $stable(pairOut[1]))
      else $error("latch not holding");
   AST_CLEAR_FORCE: assert property ((ready && nvmTripleFunc[1:0] == CLS_CODE_STORE
      && tripleIn[2] == nvmTriplePolarity[0] && $stable(tripleIn[2]))[*5]
      |-> tripleOut[0] == nvmTriplePreset[0]) else $error("clear not forcing");
   cover property (ready && hostRead && hostAddr == CLS_CHAIN1_ADDR);
   cover property (ready && nvmPairStore[0] && $rose(pairIn[0]));
   cover property (ready && nvmTripleFunc[1:0] == CLS_CODE_STORE && !tripleIn[2]);
endmodule
bind cls_logic_cells cls_logic_cells_properties i_props (.clk, .arst_n, .pairIn,
   .tripleIn, .pairOut, .tripleOut, .nvmPairTruth, .nvmPairStore, .nvmPairLatch,
   .nvmTripleTruth, .nvmTripleFunc, .nvmTriplePolarity, .nvmTriplePreset, .hostRead,
   .hostAddr, .hostRdata, .hostRdValid);

// ### cls_pkg.sv
// Constants and types shared by the combination logic cell block
package cls_pkg;
   // Cell counts and widths
   localparam int CLS_PAIR_CELLS = 2;
   localparam int CLS_TRIPLE_CELLS = 8;
   localparam int CLS_SHIFT_BASE = 4;
   localparam int CLS_SHIFT_CELLS = 4;
   localparam int CLS_CHAIN_BITS = 8;
   localparam int CLS_LEN_W = 3;
   localparam int CLS_SYNC_W = 32;

   // Byte addresses of the shift chain contents
   localparam logic [7:0] CLS_CHAIN0_ADDR = 8'h88;
   localparam logic [7:0] CLS_CHAIN1_ADDR = 8'h8A;
   localparam logic [7:0] CLS_CHAIN2_ADDR = 8'h8C;
   localparam logic [7:0] CLS_CHAIN3_ADDR = 8'h8E;

   // Function code as held in configuration
   localparam logic [1:0] CLS_CODE_TABLE = 2'h0;
   localparam logic [1:0] CLS_CODE_STORE = 2'h1;
   localparam logic [1:0] CLS_CODE_SHIFT = 2'h2;

   // Values after reset
   localparam logic [7:0] CLS_RDATA_RST = 8'h00;
   localparam logic [7:0] CLS_CHAIN_RST = 8'h00;
   localparam logic CLS_OUT_RST = 1'b0;
   localparam logic CLS_LOADED_RST = 1'b0;

   // Decoded cell function, one-hot
   typedef enum logic [2:0] {
      CLS_FN_TABLE = 3'b001,
      CLS_FN_STORE = 3'b010,
      CLS_FN_SHIFT = 3'b100
   } cls_func_t;
endpackage

// ### cls_route_model.sv
// Routing matrix model presenting routed cell inputs
`timescale 1ns/100ps
module cls_route_model (
   input wire logic clk,
   input wire logic hold,
   input wire logic [3:0] nxtPair,
   input wire logic [23:0] nxtTriple,
   input wire logic [3:0] nxtQuad,
   output logic [3:0] pairIn,
   output logic [23:0] tripleIn,
   output logic [3:0] quadIn
);
   initial begin
      pairIn = 4'h0;
      tripleIn = 24'h0;
      quadIn = 4'h0;
   end
   // Frozen while the host reads a chain
   always @(posedge clk) begin
      if (!hold) begin
         pairIn <= #1 nxtPair;
         tripleIn <= #1 nxtTriple;
         quadIn <= #1 nxtQuad;
      end
   end
endmodule
